// ===== shared/dftc_pkg.sv
// Shared constants, types and helpers for the dynamic fan threshold control block
package dftc_pkg;

	// Temperature in whole degrees, wide enough for all differences and doublings
	typedef logic signed [11:0] dftc_deg_t;

	localparam int NUM_CH  = 3;
	localparam int NUM_PWM = 3;

	////////////////////////////////////////////////////////////////////////////////
	// Register indices: byte address is four times the index
	localparam logic [7:0] IDX_OP_BASE    = 8'h33;
	localparam logic [7:0] IDX_CTRL1      = 8'h36;
	localparam logic [7:0] IDX_CTRL2      = 8'h37;
	localparam logic [7:0] IDX_LIM_BASE   = 8'h4E;
	localparam logic [7:0] IDX_START_BASE = 8'h67;
	localparam logic [7:0] IDX_HYST_BASE  = 8'h6A;
	localparam logic [7:0] IDX_CONFIG     = 8'h6D;
	localparam logic [7:0] IDX_STEP_BASE  = 8'h6E;
	localparam logic [7:0] IDX_STATUS     = 8'h71;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int CAP_LSB          = 2;
	localparam int DYN_LSB          = 5;
	localparam int R2_CODE_MSB_BIT  = 0;
	localparam int CFG_OFF64_BIT    = 0;
	localparam int CFG_SMOOTH_LSB   = 1;
	localparam int STS_OVERHEAT_BIT = 3;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0] OP_RESET     = 8'hA4;
	localparam logic [7:0] LOW_RESET    = 8'h01;
	localparam logic [7:0] HIGH_RESET   = 8'h7F;
	localparam logic [7:0] START_RESET  = 8'h5A;
	localparam logic [7:0] HYST_RESET   = 8'h04;
	localparam logic [7:0] STEP_RESET   = 8'h01;
	localparam logic [7:0] CTRL_RESET   = 8'h00;
	localparam logic [7:0] CONFIG_RESET = 8'h00;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// Loop arithmetic: floors are -127 and -64 degrees
	localparam dftc_deg_t OFF64_BIAS  = 12'h040;
	localparam dftc_deg_t FLOOR_TWOS  = 12'hF81;
	localparam dftc_deg_t FLOOR_OFF64 = 12'hFC0;
	localparam dftc_deg_t LONG_STEP   = 12'h001;
	localparam logic [11:0] SHORT_BASE = 12'h008;

	function automatic dftc_deg_t to_deg(input logic [7:0] raw, input logic off64);
		return off64 ? dftc_deg_t'({4'h0, raw}) - OFF64_BIAS : dftc_deg_t'({{4{raw[7]}}, raw});
	endfunction

	function automatic logic [7:0] from_deg(input dftc_deg_t d, input logic off64);
		dftc_deg_t t;
		t = off64 ? d + OFF64_BIAS : d;
		return t[7:0];
	endfunction

	// Short cycle length in monitoring cycles; code 0 gives 8, each step doubles
	function automatic logic [11:0] cyc_len(input logic [2:0] code);
		return SHORT_BASE << code;
	endfunction

endpackage

// ===== shared/dftc_chan_if.sv
// Per-channel carrier between the register block and one control loop
interface dftc_chan_if;
	logic                tick;
	logic                off64;
	logic                dyn_en;
	logic [2:0]          code;
	dftc_pkg::dftc_deg_t temp;
	dftc_pkg::dftc_deg_t op;
	dftc_pkg::dftc_deg_t low;
	dftc_pkg::dftc_deg_t high;
	dftc_pkg::dftc_deg_t hyst;
	logic                wr_en;
	logic [7:0]          wr_data;
	logic [7:0]          start;
	logic                below;

	modport chan (input tick, off64, dyn_en, code, temp, op, low, high, hyst, wr_en, wr_data,
		output start, below);
	modport ctrl (output tick, off64, dyn_en, code, temp, op, low, high, hyst, wr_en, wr_data,
		input start, below);
endinterface

// ===== logic/dftc_chan.sv
// One temperature channel's fan start temperature adjustment loop
module dftc_chan
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Channel carrier
	dftc_chan_if.chan ch
);
	logic [11:0]         cnt;
	dftc_pkg::dftc_deg_t prev_temp;
	logic [7:0]          start;

	wire logic [11:0] n_len      = dftc_pkg::cyc_len(ch.code);
	wire logic [11:0] n2_len     = n_len << 1;
	wire logic        long_hit   = ch.tick && (cnt == n2_len - 12'h001);
	wire logic        short_hit  = ch.tick && (cnt == n_len - 12'h001 || long_hit);
	wire dftc_pkg::dftc_deg_t start_deg = dftc_pkg::to_deg(start, ch.off64);
	wire dftc_pkg::dftc_deg_t floor_deg = ch.off64 ? dftc_pkg::FLOOR_OFF64 : dftc_pkg::FLOOR_TWOS;
	wire dftc_pkg::dftc_deg_t rise      = ch.temp - prev_temp;
	wire dftc_pkg::dftc_deg_t bound     = (ch.high < ch.op) ? ch.high : ch.op;
	wire logic below    = ch.temp < start_deg;
	wire logic active   = ch.dyn_en && !below;
	wire logic dec_s    = short_hit && (ch.temp > ch.op - ch.hyst) && (rise > 0);
	wire logic dec_l    = long_hit && (ch.temp > ch.op);
	wire dftc_pkg::dftc_deg_t dec_tot =
		(dec_s ? rise <<< 1 : 12'h000) + (dec_l ? dftc_pkg::LONG_STEP : 12'h000);
	wire logic inc_ok   = long_hit && ch.temp < ch.low
		&& start_deg < ch.high && start_deg < ch.op;
	wire dftc_pkg::dftc_deg_t lowered  = start_deg - dec_tot;
	wire dftc_pkg::dftc_deg_t raised   = start_deg + dftc_pkg::LONG_STEP;
	wire dftc_pkg::dftc_deg_t next_deg =
		(dec_tot != 12'h000) ? ((lowered < floor_deg) ? floor_deg : lowered)
		: ((raised > bound) ? bound : raised);
	wire logic adjust   = active && (dec_tot != 12'h000 || inc_ok);

	assign ch.start = start;
	assign ch.below = below;

	always_ff @(posedge aclk)
	begin
		if (!aresetn || cnt >= n2_len - 12'h001 && ch.tick)
			cnt <= 12'h000;
		else if (ch.tick)
			cnt <= cnt + 12'h001;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			prev_temp <= '0;
		else if (ch.tick)
			prev_temp <= ch.temp;
	end

	// Host write wins over the loop so software can always re-seed the value
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			start <= dftc_pkg::START_RESET;
		else if (ch.wr_en)
			start <= ch.wr_data;
		else if (adjust)
			start <= dftc_pkg::from_deg(next_deg, ch.off64);
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// A format switch re-reads the same raw value, which is no raise
	rise_long_a: assert property (!ch.wr_en && !long_hit
		|=> $changed(ch.off64) || start_deg <= $past(start_deg))
		else $error("start temperature rose outside a long cycle");
	rise_high_a: assert property (!ch.wr_en && start_deg >= ch.high
		|=> $changed(ch.off64) || start_deg <= $past(start_deg))
		else $error("start temperature rose at or above high limit");
	rise_op_a: assert property (!ch.wr_en && start_deg < ch.op
		&& start_deg < ch.high |=> $changed(ch.off64) || start_deg <= $past(ch.op))
		else $error("start temperature passed operating point");
	suspend_a: assert property (!ch.wr_en && (below || !ch.dyn_en) |=> $stable(start))
		else $error("start temperature moved while suspended or disabled");
	warm_hold_a: assert property (!ch.wr_en && ch.temp >= ch.low
		|=> $changed(ch.off64) || start_deg <= $past(start_deg))
		else $error("start temperature rose above low limit");
	floor_a: assert property (adjust && !ch.wr_en && dec_tot != 12'h000
		|=> start_deg >= $past(floor_deg))
		else $error("start temperature fell below floor");
	long_drop_a: assert property (active && !ch.wr_en && dec_l && !dec_s
		&& start_deg > floor_deg |=> start_deg == $past(start_deg) - 12'h001)
		else $error("long cycle did not lower by one degree");
endmodule

// ===== logic/dftc_smooth.sv
// Fan-centric duty smoothing for one PWM output
module dftc_smooth
#(
	parameter int DUTY_W = 8
)
(
	// Clock and reset
	input wire logic              aclk,
	input wire logic              aresetn,
	// Control
	input wire logic              update,
	input wire logic              smooth_en,
	input wire logic [DUTY_W-1:0] step,
	input wire logic [DUTY_W-1:0] target,
	// Output
	output logic     [DUTY_W-1:0] duty
);
	wire logic              up      = target > duty;
	wire logic [DUTY_W-1:0] gap     = up ? target - duty : duty - target;
	wire logic [DUTY_W-1:0] moved   = up ? duty + step : duty - step;
	// Landing on the target instead of stepping past it stops limit cycling
	wire logic [DUTY_W-1:0] next_duty = !smooth_en ? target : (gap > step) ? moved : target;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			duty <= '0;
		else if (update)
			duty <= next_duty;
	end

	sequence step_due_s;
		update && smooth_en && (gap > step);
	endsequence

	direct_a: assert property (@(posedge aclk) disable iff (!aresetn)
		update && !smooth_en |=> duty == $past(target))
		else $error("unsmoothed duty not applied at once");
	step_a: assert property (@(posedge aclk) disable iff (!aresetn)
		step_due_s |=> (duty == $past(duty) + $past(step)) || (duty == $past(duty) - $past(step)))
		else $error("smoothed duty did not move by one step");
	toward_a: assert property (@(posedge aclk) disable iff (!aresetn)
		update && smooth_en && up |=> duty > $past(duty) && duty <= $past(target))
		else $error("smoothed duty did not move toward target");
	toward_down_a: assert property (@(posedge aclk) disable iff (!aresetn)
		update && smooth_en && !up && duty != target |=> duty < $past(duty) && duty >= $past(target))
		else $error("smoothed duty did not move down toward target");
endmodule

// ===== logic/dftc_top.sv
// Dynamic fan start temperature control with acoustic smoothing, AXI4-Lite registers
//
// Contract
// - Raise fan start temperature only in the channel's long cycle, while below low limit.
// - Raise only while start temperature is below high limit; never beyond it.
// - Raise only while start temperature is below operating point; never past it.
// - Temperature below start temperature: fan off or minimum, adjustment suspended.
// - Once temperature climbs above low limit, stop raising and hold.
// - Lowering clamps at -127 degrees, or -64 in offset-64 format.
// - Remote 2 capture bit set: overheat low copies temperature into operating point.
// - Local capture bit set: overheat low copies temperature into operating point.
// - Remote 1 capture bit set: overheat low copies temperature into operating point.
// - Remote 2 dynamic enable set: adjust; clear: value stays as programmed.
// - Local dynamic enable set: adjust; clear: value stays as programmed.
// - Remote 1 dynamic enable set: adjust; clear: value stays as programmed.
// - Without smoothing, each computed duty applies at once.
// - With smoothing, duty change per update is limited to a fixed step.
// - Smoothed duty moves by the step toward the target, up and down.
// - Smoothing is enabled per PWM output independently.
// - Short cycle every n monitoring cycles, long every 2n; code 000 gives 8.
// - Above operating point, lower start temperature one degree each long cycle.
// - Above operating point minus hysteresis, short cycle lowers two per degree of rise.
module dftc_top
#(
	parameter int ADDR_W = 12
)
(
	// Clock and reset
	input wire logic                aclk,
	input wire logic                aresetn,
	// AXI4-Lite write address
	input wire logic                s_axi_awvalid,
	output logic                    s_axi_awready,
	input wire logic [ADDR_W-1:0]   s_axi_awaddr,
	input wire logic [2:0]          s_axi_awprot,
	// AXI4-Lite write data
	input wire logic                s_axi_wvalid,
	output logic                    s_axi_wready,
	input wire logic [31:0]         s_axi_wdata,
	input wire logic [3:0]          s_axi_wstrb,
	// AXI4-Lite write response
	output logic                    s_axi_bvalid,
	input wire logic                s_axi_bready,
	output logic [1:0]              s_axi_bresp,
	// AXI4-Lite read address
	input wire logic                s_axi_arvalid,
	output logic                    s_axi_arready,
	input wire logic [ADDR_W-1:0]   s_axi_araddr,
	input wire logic [2:0]          s_axi_arprot,
	// AXI4-Lite read data
	output logic                    s_axi_rvalid,
	input wire logic                s_axi_rready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	// Measurements: index 0 remote 1, 1 local, 2 remote 2
	input wire logic                monitor_tick,
	input wire logic [2:0][7:0]     chan_temp,
	input wire logic                overheat_signal_n,
	// Fan control
	input wire logic [2:0][7:0]     duty_calc,
	output logic     [2:0][7:0]     pwm_duty,
	output logic     [2:0][7:0]     fan_start_temp,
	output logic     [2:0]          fan_off
);
	logic [7:0]      op [3];
	logic [7:0]      lim [6];
	logic [7:0]      hyst [3];
	logic [7:0]      step [3];
	logic [7:0]      ctrl1;
	logic [7:0]      ctrl2;
	logic [7:0]      config_r;
	logic            aw_held;
	logic            w_held;
	logic [7:0]      wr_idx;
	logic            wr_map;
	logic [7:0]      wdata_q;
	logic            wstrb_q;
	logic [7:0]      rd_val;
	logic            rd_ok;
	logic [2:0]      below;

	////////////////////////////////////////////////////////////////////////////////
	// Address decoding

	function automatic logic in_rng(input logic [7:0] idx, input logic [7:0] base,
		input logic [7:0] cnt);
		return idx >= base && idx < base + cnt;
	endfunction

	function automatic logic mapped(input logic [7:0] idx);
		return in_rng(idx, dftc_pkg::IDX_OP_BASE, 8'h05) || in_rng(idx, dftc_pkg::IDX_LIM_BASE, 8'h06)
			|| in_rng(idx, dftc_pkg::IDX_START_BASE, 8'h0B);
	endfunction

	function automatic logic [7:0] addr_idx(input logic [ADDR_W-1:0] a);
		return a[9:2];
	endfunction

	function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
		return a[1:0] == 2'h0 && (a >> 10) == '0 && mapped(a[9:2]);
	endfunction

	wire logic       off64     = config_r[dftc_pkg::CFG_OFF64_BIT];
	wire logic [7:0] rd_idx    = addr_idx(s_axi_araddr);
	wire logic       wr_fire   = aw_held && w_held && !s_axi_bvalid;
	wire logic       wr_sel    = wr_fire && wr_map && wstrb_q;
	// Protection bits carry no meaning here
	wire logic       prot_unused = ^{s_axi_awprot, s_axi_arprot};

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write path: address and data taken in either order, then one response

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn || wr_fire)
			aw_held <= 1'b0;
		else if (s_axi_awvalid && s_axi_awready)
			aw_held <= 1'b1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || wr_fire)
			w_held <= 1'b0;
		else if (s_axi_wvalid && s_axi_wready)
			w_held <= 1'b1;
	end

	always_ff @(posedge aclk)
	begin
		if (s_axi_awvalid && s_axi_awready)
		begin
			wr_idx <= addr_idx(s_axi_awaddr);
			wr_map <= addr_ok(s_axi_awaddr);
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			wdata_q <= s_axi_wdata[7:0];
			wstrb_q <= s_axi_wstrb[0];
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_axi_bvalid <= 1'b0;
		else if (wr_fire)
			s_axi_bvalid <= 1'b1;
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_axi_bresp <= dftc_pkg::RESP_OKAY;
		else if (wr_fire)
			s_axi_bresp <= wr_map ? dftc_pkg::RESP_OKAY : dftc_pkg::RESP_SLVERR;
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read path: data one cycle after the address is taken

	assign s_axi_arready = !s_axi_rvalid;

	always_comb
	begin
		rd_val = 8'h00;
		rd_ok  = addr_ok(s_axi_araddr);
		if (in_rng(rd_idx, dftc_pkg::IDX_OP_BASE, 8'h03))
			rd_val = op[2'(rd_idx - dftc_pkg::IDX_OP_BASE)];
		else if (rd_idx == dftc_pkg::IDX_CTRL1)
			rd_val = ctrl1;
		else if (rd_idx == dftc_pkg::IDX_CTRL2)
			rd_val = ctrl2;
		else if (in_rng(rd_idx, dftc_pkg::IDX_LIM_BASE, 8'h06))
			rd_val = lim[3'(rd_idx - dftc_pkg::IDX_LIM_BASE)];
		else if (in_rng(rd_idx, dftc_pkg::IDX_START_BASE, 8'h03))
			rd_val = fan_start_temp[2'(rd_idx - dftc_pkg::IDX_START_BASE)];
		else if (in_rng(rd_idx, dftc_pkg::IDX_HYST_BASE, 8'h03))
			rd_val = hyst[2'(rd_idx - dftc_pkg::IDX_HYST_BASE)];
		else if (rd_idx == dftc_pkg::IDX_CONFIG)
			rd_val = config_r;
		else if (in_rng(rd_idx, dftc_pkg::IDX_STEP_BASE, 8'h03))
			rd_val = step[2'(rd_idx - dftc_pkg::IDX_STEP_BASE)];
		else if (rd_idx == dftc_pkg::IDX_STATUS)
			rd_val = {4'h0, !overheat_signal_n, below};
		if (!rd_ok)
			rd_val = 8'h00;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_axi_rvalid <= 1'b0;
		else if (s_axi_arvalid && s_axi_arready)
			s_axi_rvalid <= 1'b1;
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= dftc_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rdata <= {24'h000000, rd_val};
			s_axi_rresp <= rd_ok ? dftc_pkg::RESP_OKAY : dftc_pkg::RESP_SLVERR;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register storage

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl1    <= dftc_pkg::CTRL_RESET;
			ctrl2    <= dftc_pkg::CTRL_RESET;
			config_r <= dftc_pkg::CONFIG_RESET;
		end
		else if (wr_sel)
		begin
			if (wr_idx == dftc_pkg::IDX_CTRL1)
				ctrl1 <= wdata_q;
			if (wr_idx == dftc_pkg::IDX_CTRL2)
				ctrl2 <= wdata_q;
			if (wr_idx == dftc_pkg::IDX_CONFIG)
				config_r <= wdata_q;
		end
	end

	always_ff @(posedge aclk)
	begin
		for (int i = 0; i < 6; i++)
			if (!aresetn)
				lim[i] <= i[0] ? dftc_pkg::HIGH_RESET : dftc_pkg::LOW_RESET;
			else if (wr_sel && wr_idx == dftc_pkg::IDX_LIM_BASE + 8'(i))
				lim[i] <= wdata_q;
	end

	// The overheat capture beats a host write in the same cycle
	always_ff @(posedge aclk)
	begin
		for (int i = 0; i < 3; i++)
			if (!aresetn)
			begin
				op[i]   <= dftc_pkg::OP_RESET;
				hyst[i] <= dftc_pkg::HYST_RESET;
				step[i] <= dftc_pkg::STEP_RESET;
			end
			else
			begin
				if (!overheat_signal_n && ctrl1[dftc_pkg::CAP_LSB + i])
					op[i] <= chan_temp[i];
				else if (wr_sel && wr_idx == dftc_pkg::IDX_OP_BASE + 8'(i))
					op[i] <= wdata_q;
				if (wr_sel && wr_idx == dftc_pkg::IDX_HYST_BASE + 8'(i))
					hyst[i] <= wdata_q;
				if (wr_sel && wr_idx == dftc_pkg::IDX_STEP_BASE + 8'(i))
					step[i] <= wdata_q;
			end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			fan_off <= 3'h0;
		else
			fan_off <= below;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Channel loops and output smoothing

	dftc_chan_if chif [3] ();

	wire logic [2:0] code_r1 = ctrl2[2:0];
	wire logic [2:0] code_lc = ctrl2[5:3];
	wire logic [2:0] code_r2 = {ctrl1[dftc_pkg::R2_CODE_MSB_BIT], ctrl2[7:6]};

	for (genvar gi = 0; gi < 3; gi++)
	begin : g_ch
		assign chif[gi].tick    = monitor_tick;
		assign chif[gi].off64   = off64;
		assign chif[gi].dyn_en  = ctrl1[dftc_pkg::DYN_LSB + gi];
		assign chif[gi].code    = (gi == 0) ? code_r1 : (gi == 1) ? code_lc : code_r2;
		assign chif[gi].temp    = dftc_pkg::to_deg(chan_temp[gi], off64);
		assign chif[gi].op      = dftc_pkg::to_deg(op[gi], off64);
		assign chif[gi].low     = dftc_pkg::to_deg(lim[2 * gi], off64);
		assign chif[gi].high    = dftc_pkg::to_deg(lim[2 * gi + 1], off64);
		assign chif[gi].hyst    = dftc_pkg::dftc_deg_t'({4'h0, hyst[gi]});
		assign chif[gi].wr_en   = wr_sel && wr_idx == dftc_pkg::IDX_START_BASE + 8'(gi);
		assign chif[gi].wr_data = wdata_q;
		assign fan_start_temp[gi] = chif[gi].start;
		assign below[gi]          = chif[gi].below;

		dftc_chan u_chan
		(
			.aclk    (aclk),
			.aresetn (aresetn),
			.ch      (chif[gi])
		);

		// Each output has its own enable, even when outputs share a channel
		dftc_smooth #(.DUTY_W(8)) u_smooth
		(
			.aclk      (aclk),
			.aresetn   (aresetn),
			.update    (monitor_tick),
			.smooth_en (config_r[dftc_pkg::CFG_SMOOTH_LSB + gi]),
			.step      (step[gi]),
			.target    (duty_calc[gi]),
			.duty      (pwm_duty[gi])
		);

		cap_copy_a: assert property (@(posedge aclk) disable iff (!aresetn)
			!overheat_signal_n && ctrl1[dftc_pkg::CAP_LSB + gi] |=> op[gi] == $past(chan_temp[gi]))
			else $error("operating point not captured on overheat");
		cap_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
			!ctrl1[dftc_pkg::CAP_LSB + gi] && !wr_sel |=> $stable(op[gi]))
			else $error("operating point changed with capture off");
	end
endmodule

// ===== tb/dftc_cpu_hot_model.sv
// Processor hot output model driving the active-low overheat input
module dftc_cpu_hot_model
(
	// Clock
	input wire logic aclk,
	// Throttle request from the bench
	input wire logic throttle,
	// Overheat pin
	output logic     overheat_signal_n
);
	timeunit 1ns;
	timeprecision 1ps;
	initial overheat_signal_n = 1'b1;
	// Throttling pulls the pin low; it idles high so no stray capture happens
	always @(posedge aclk)
		overheat_signal_n <= !throttle;
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the dynamic fan start temperature control block
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0;
	logic rr = 1'b0, tick = 1'b0, thr = 1'b0;
	logic [11:0] awa = 12'h000, ara = 12'h000;
	logic [31:0] wd = 32'h0, rd;
	logic [2:0][7:0] temp = '0, duty = '0, es, pwm, st;
	logic [1:0] bre, rre;
	logic [2:0] off;
	logic awr, wrdy, bv, arr, rv, ovh_n;
	int err_total = 0;
	int n_compared = 0;
	always #2 aclk = ~aclk;
	dftc_cpu_hot_model hot (.aclk(aclk), .throttle(thr), .overheat_signal_n(ovh_n));
	dftc_top dut
	(
		.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_bresp(bre), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
		.s_axi_arprot(3'h0), .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd),
		.s_axi_rresp(rre), .monitor_tick(tick), .chan_temp(temp), .overheat_signal_n(ovh_n),
		.duty_calc(duty), .pwm_duty(pwm), .fan_start_temp(st), .fan_off(off)
	);
	////////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Address and data are offered together; each is dropped once taken
	task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er = 2'h0);
		logic a, w;
		@(posedge aclk);
		awa <= {2'h0, idx, 2'h0};
		wd <= {24'h0, d};
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		a = 1'b1;
		w = 1'b1;
		// Only the watchdog ends a wait: the master puts no bound on latency
		while (a || w)
		begin
			@(negedge aclk);
			a = a && !awr;
			w = w && !wrdy;
			@(posedge aclk);
			awv <= a;
			wv <= w;
		end
		do
			@(negedge aclk);
		while (!bv);
		chk({30'h0, bre}, {30'h0, er});
		@(posedge aclk);
		br <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] er = 2'h0);
		@(posedge aclk);
		ara <= {2'h0, idx, 2'h0};
		arv <= 1'b1;
		rr <= 1'b1;
		do
			@(negedge aclk);
		while (!arr);
		@(posedge aclk);
		arv <= 1'b0;
		do
			@(negedge aclk);
		while (!rv);
		chk(rd, {24'h0, exp});
		chk({30'h0, rre}, {30'h0, er});
		@(posedge aclk);
		rr <= 1'b0;
	endtask
	task automatic wr3(input logic [7:0] base, input int stride, input logic [7:0] v);
		for (int c = 0; c < 3; c++)
			wr(base + 8'(stride * c), v);
	endtask
	task automatic tk(input int n);
		repeat (n)
		begin
			@(posedge aclk);
			tick <= 1'b1;
		end
		@(posedge aclk);
		tick <= 1'b0;
		@(negedge aclk);
	endtask
	task automatic st3(input logic [7:0] v);
		@(posedge aclk);
		temp <= {3{v}};
	endtask
	task automatic trip();
		@(posedge aclk);
		thr <= 1'b1;
		repeat (3) @(posedge aclk);
		thr <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk({8'h0, st}, 32'h005A5A5A);
		rchk(dftc_pkg::IDX_OP_BASE, 8'hA4);
		rchk(dftc_pkg::IDX_CTRL1, 8'h00);
		rchk(8'h00, 8'h00, dftc_pkg::RESP_SLVERR);
		wr(8'h01, 8'h55, dftc_pkg::RESP_SLVERR);
		$display("reset test done");
	endtask
	task automatic t_capture();
		wr(dftc_pkg::IDX_CTRL1, 8'h1C);
		temp <= {8'h33, 8'h22, 8'h11};
		trip();
		for (int c = 0; c < 3; c++)
			rchk(dftc_pkg::IDX_OP_BASE + 8'(c), 8'(8'h11 * (c + 1)));
		wr(dftc_pkg::IDX_CTRL1, 8'h00);
		st3(8'h70);
		trip();
		for (int c = 0; c < 3; c++)
			rchk(dftc_pkg::IDX_OP_BASE + 8'(c), 8'(8'h11 * (c + 1)));
		$display("capture test done");
	endtask
	// Channel 0 runs code 1, the others code 0, so counts differ per channel
	task automatic t_raise();
		wr3(dftc_pkg::IDX_LIM_BASE, 2, 8'h30);
		wr3(dftc_pkg::IDX_LIM_BASE + 8'h01, 2, 8'h7F);
		wr3(dftc_pkg::IDX_OP_BASE, 1, 8'h40);
		wr3(dftc_pkg::IDX_START_BASE, 1, 8'h10);
		wr(dftc_pkg::IDX_CTRL2, 8'h01);
		wr(dftc_pkg::IDX_CTRL1, 8'hE0);
		st3(8'h20);
		tk(16);
		chk({8'h0, st}, 32'h00111110);
		tk(16);
		chk({8'h0, st}, 32'h00121211);
		wr(dftc_pkg::IDX_CTRL2, 8'h00);
		wr(dftc_pkg::IDX_LIM_BASE + 8'h01, 8'h11);
		wr(dftc_pkg::IDX_OP_BASE + 8'h01, 8'h13);
		@(posedge aclk);
		temp <= {8'h20, 8'h13, 8'h20};
		tk(32);
		chk({8'h0, st}, 32'h00141311);
		wr(dftc_pkg::IDX_OP_BASE + 8'h01, 8'h40);
		st3(8'h35);
		tk(16);
		chk({8'h0, st}, 32'h00141311);
		$display("raise test done");
	endtask
	task automatic t_lower();
		es = {8'h14, 8'h13, 8'h11};
		st3(8'h45);
		for (int c = 0; c < 3; c++)
		begin
			wr(dftc_pkg::IDX_CTRL1, 8'h20 << c);
			tk(16);
			es[c] = es[c] - 8'h01;
			chk({8'h0, st}, {8'h0, es});
		end
		wr(dftc_pkg::IDX_CTRL1, 8'hE0);
		st3(8'h3D);
		tk(7);
		st3(8'h40);
		tk(9);
		chk({8'h0, st}, {8'h0, es} - 32'h00060606);
		chk({29'h0, off}, 32'h0);
		$display("lower test done");
	endtask
	task automatic t_floor();
		wr3(dftc_pkg::IDX_OP_BASE, 1, 8'h80);
		wr3(dftc_pkg::IDX_START_BASE, 1, 8'h82);
		st3(8'h85);
		tk(32);
		chk({8'h0, st}, 32'h00818181);
		wr(dftc_pkg::IDX_CONFIG, 8'h01);
		wr3(dftc_pkg::IDX_OP_BASE, 1, 8'h00);
		wr3(dftc_pkg::IDX_START_BASE, 1, 8'h01);
		st3(8'h05);
		tk(32);
		chk({8'h0, st}, 32'h0);
		wr(dftc_pkg::IDX_CONFIG, 8'h00);
		wr3(dftc_pkg::IDX_OP_BASE, 1, 8'h40);
		wr3(dftc_pkg::IDX_START_BASE, 1, 8'h50);
		st3(8'h45);
		tk(16);
		chk({8'h0, st}, 32'h00505050);
		chk({29'h0, off}, 32'h7);
		$display("floor test done");
	endtask
	// Only the middle output is smoothed although all share one target
	task automatic t_smooth();
		wr(dftc_pkg::IDX_CTRL1, 8'h00);
		wr(dftc_pkg::IDX_CONFIG, 8'h04);
		wr(dftc_pkg::IDX_STEP_BASE + 8'h01, 8'h03);
		@(posedge aclk);
		duty <= {3{8'h0A}};
		tk(1);
		chk({8'h0, pwm}, 32'h000A030A);
		tk(3);
		chk({8'h0, pwm}, 32'h000A0A0A);
		@(posedge aclk);
		duty <= '0;
		tk(1);
		chk({8'h0, pwm}, 32'h00000700);
		$display("smoothing test done");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		t_reset();
		t_capture();
		t_raise();
		t_lower();
		t_floor();
		t_smooth();
		give_verdict();
	end
	// Whole run needs well under a thousand cycles; this limit only catches a hang
	initial
	begin
		repeat (20000) @(posedge aclk);
		err_total++;
		give_verdict();
	end
endmodule
